// ---- bench/mbx_exec_tb_top.sv ----
// Self-checking bench running one program through the execution core
`timescale 1ns/1ns
`default_nettype none
module mbx_exec_tb_top;
    import mbx_pkg::*;
    logic clk = 1'b0, rst = 1'b1, irq_req = 1'b0, wake_req = 1'b0;
    logic [10:0] prog_addr;
    mbx_instr_t prog_data;
    logic [7:0] io_raddr, io_rdata;
    mbx_io_wr_t io_wr;
    logic gie, halt_cpu, halt_osc, soft_reset, wdt_clear;
    mbx_status_t status;
    logic [55:0] obs;
    int n_fail = 0, samples_checked = 0;
    // Every word not loaded below flips the accumulator, so a discarded fetch that executes shows up
    mbx_op_t ops [25] = '{op_ceqsn, op_or, op_not, op_neg, op_and, op_xor, op_xor_io, op_bit_set_io, op_swapc,
        op_cneqsn, op_ceqsn, op_xor, op_or, op_izsn, op_xor, op_dzsn, op_call, op_skip_if_bit_high_io, op_xor,
        op_bit_set_mem, op_skip_if_bit_high_mem, op_bit_set_mem, op_skip_if_bit_high_mem, op_xor, op_pcadd};
    // Bit number above the operand byte
    logic [10:0] wv [25] = '{11'h1, 11'h38, 11'h0, 11'h0, 11'h0, 11'h5a, 11'h10, 11'h311, 11'h12, 11'h5a, 11'h5a,
        11'hff, 11'hff, 11'h0, 11'hff, 11'h0, 11'h0, 11'h311, 11'hff, 11'h40, 11'h40, 11'h13f, 11'h13f, 11'hff, 11'h0};
    // Per edge: pc, accumulator, flags, gie and watchdog pulse, sp, halts, reset pulse, IO write; zero skips
    logic [55:0] exp_t [61] = '{56'h02000004000000, 56'h02000004000000, 56'h02100604000000, 56'h02238604000000,
        56'h023c7604000000, 56'h02439604000000, 56'h02500e04000000, 56'h0265a604000000, 56'h0275a604011055,
        56'h0285a604011108, 56'h0295a204011201, 56'h02a5a804000000, 56'h02b5a804000000, 56'h02c5a804000000,
        56'h02dff004000000, 56'h02e00e04000000, 56'h02f00e04000000, 56'h030ff604000000, 56'h100ff604000000,
        56'h100ff604200000, 56'h0, 56'h03177604000000, 56'h03277604000000, 56'h03377604000000,
        56'h03477604000000, 56'h03577604000000, 56'h03677604000000, 56'h03777604000000, 56'h03877604000000,
        56'h0af77604000000, 56'h0af77604000000, 56'h0b077624000000, 56'h0b177634000000, 56'h01077604000000,
        56'h01077604200000, 56'h0, 56'h0b177624000000, 56'h0b277604000000, 56'h0b377604080000,
        56'h0b377604080000, 56'h0, 56'h0b4776040c0000, 56'h0, 56'h0b577604020000, 56'h0b688604000000,
        56'h0b788604000000, 56'h0b888604000000, 56'h0b988604000000, 56'h0b988604000000,
        56'h0ba77604000000, 56'h0bb77e04000000, 56'h0bc77e04000000, 56'h0bc00e04000000,
        56'h0bd00e04000000, 56'h0be00e04000000, 56'h0bf00e04000000, 56'h0c800e04000000,
        56'h0c800e04200000, 56'h0c900e04200000, 56'h0c000e04000000, 56'h0c1ff604000000};
    assign obs = {1'b0, prog_addr, status.accumulator, status.flags, 2'b00, gie, wdt_clear, status.sp, halt_cpu,
        halt_osc, soft_reset, io_wr.we, io_wr.we ? {io_wr.addr, io_wr.data} : 16'h0000};
    always #20 clk = ~clk;
    mbx_exec u_dut (.clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data), .io_raddr(io_raddr),
        .io_rdata(io_rdata), .io_wr(io_wr), .irq_req(irq_req), .wake_req(wake_req), .gie(gie),
        .halt_cpu(halt_cpu), .halt_osc(halt_osc), .soft_reset(soft_reset), .wdt_clear(wdt_clear), .status(status));
    mbx_far_side u_far (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .io_raddr(io_raddr),
        .io_rdata(io_rdata), .io_wr(io_wr));
    task automatic chk(input logic [55:0] s, input logic [55:0] x);
        samples_checked++;
        if (s !== x) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic t();
        @(posedge clk);
        #1;
    endtask : t
    task automatic p(input logic [10:0] ad, input mbx_op_t o, input logic [10:0] w, input logic [10:0] g = 11'h100,
        input logic m = 1'b0, input logic im = 1'b1);
        u_far.rom[ad] = '{o, m, im, w[7:0], w[10:8], g};
    endtask : p
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    initial begin
        for (int i = 0; i < 2048; i++) begin
            p(11'(i), op_xor, 11'hff);
            u_far.io[8'(i)] = 8'h00;
        end
        u_far.io[8'h10] = 8'h0f;
        for (int i = 0; i < 25; i++) begin
            p(11'(i + 32), ops[i], wv[i]);
        end
        p(11'h000, op_goto, 11'h0, 11'h020);
        p(11'h100, op_ret_imm, 11'h77);
        p(11'h0af, op_engint, 11'h0);
        p(11'h0b0, op_wdreset, 11'h0);
        p(11'h010, op_reti, 11'h0);
        p(11'h0b1, op_disgint, 11'h0);
        p(11'h0b2, op_stopexe, 11'h0);
        p(11'h0b3, op_stopsys, 11'h0);
        p(11'h0b4, op_reset, 11'h0);
        p(11'h0b6, op_skip_if_bit_low_io, 11'h112);
        p(11'h0b8, op_idxm_wr, 11'h041);
        // Memory operand and memory destination on the byte that idxm just wrote
        p(11'h0ba, op_and, 11'h000, 11'h100, 1'b1, 1'b0);
        p(11'h0bb, op_idxm_rd, 11'h041);
        p(11'h0bc, op_skip_if_bit_low_mem, 11'h300);
        p(11'h0be, op_nop, 11'h0);
        p(11'h0bf, op_call, 11'h0, 11'h0c8);
        p(11'h0c8, op_ret, 11'h0);
        repeat (4) t();
        rst = 1'b0;
        chk(obs, 56'h00000004000000);
        for (int k = 0; k < 61; k++) begin
            t();
            if (exp_t[k] !== 56'h0) begin
                chk(obs, exp_t[k]);
            end
            if (k == 8) begin
                chk({48'h0, io_raddr}, 56'h11);
            end
            irq_req = (k == 32);
            wake_req = (k == 39 || k == 41);
        end
        // The core only pulses its reset request; the surrounding logic turns it into a reset
        rst = 1'b1;
        t();
        rst = 1'b0;
        chk(obs, 56'h00000004000000);
        close_out();
    end
endmodule : mbx_exec_tb_top
`default_nettype wire

// ---- bench/mbx_far_side.sv ----
// Program memory and IO register space facing the execution core
`timescale 1ns/1ns
`default_nettype none
module mbx_far_side
    import mbx_pkg::*;
(
    input wire logic clk,
    input wire logic [10:0] prog_addr,
    output var mbx_pkg::mbx_instr_t prog_data,
    input wire logic [7:0] io_raddr,
    output logic [7:0] io_rdata,
    input wire mbx_pkg::mbx_io_wr_t io_wr
);
    mbx_instr_t rom [0:2047];
    logic [7:0] io [0:255];
    // Reads are combinational, as the core expects them in the same cycle
    assign prog_data = rom[prog_addr];
    assign io_rdata = io[io_raddr];
    // Plain always: the bench also preloads this array
    always @(posedge clk) begin
        if (io_wr.we) begin
            io[io_wr.addr] <= io_wr.data;
        end
    end
endmodule : mbx_far_side
`default_nettype wire

// ---- rtl/mbx_data_ram.sv ----
// Data RAM of the core, one combinational read port and one write port
`timescale 1ns/1ns
`default_nettype none
module mbx_data_ram
    import mbx_pkg::*;
(
    input wire logic clk,
    input wire logic [RAM_AW-1:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [RAM_AW-1:0] waddr,
    input wire logic [7:0] wdata
);
    // Contents are undefined after reset, as on the real part
    logic [7:0] mem [RAM_DEPTH];

    assign rdata = mem[raddr];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule : mbx_data_ram
`default_nettype wire

// ---- rtl/mbx_exec.sv ----
// Execution core for logic, bit, skip and system control instructions
`timescale 1ns/1ns
`default_nettype none
module mbx_exec (
    input wire logic clk,
    input wire logic rst,
    output logic [10:0] prog_addr,
    input wire mbx_pkg::mbx_instr_t prog_data,
    output logic [7:0] io_raddr,
    input wire logic [7:0] io_rdata,
    output var mbx_pkg::mbx_io_wr_t io_wr,
    input wire logic irq_req,
    input wire logic wake_req,
    output logic gie,
    output logic halt_cpu,
    output logic halt_osc,
    output logic soft_reset,
    output logic wdt_clear,
    output var mbx_pkg::mbx_status_t status
);
    import mbx_pkg::*;

    mbx_state_t st;
    mbx_state_t next_st;
    mbx_instr_t ir;
    logic take_irq;
    logic exec;
    logic [7:0] opnd;
    logic [7:0] src;
    logic [7:0] bmask;
    logic bit_ok;
    logic [10:0] pc_inc;
    mbx_alu_t cmp_r;
    mbx_alu_t inc_r;
    mbx_alu_t dec_r;
    logic [7:0] res;
    logic put;
    logic [RAM_AW-1:0] ram_raddr;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [RAM_AW-1:0] ram_waddr;
    logic [7:0] ram_wdata;

    assign ir = prog_data;
    // Requests wait for an instruction boundary
    assign take_irq = st.gie && irq_req && (st.phase == ph_run);
    assign exec = (st.phase == ph_run) && !take_irq;
    assign opnd = ir.use_imm ? ir.val : ram_rdata;
    assign src = ir.to_mem ? ram_rdata : st.accumulator;
    assign bmask = BYTE_ONE << ir.bitn;
    assign bit_ok = (ir.val <= BIT_RAM_LAST);
    assign pc_inc = st.pc + PC_STEP;
    assign cmp_r = mbx_addsub(st.accumulator, opnd, 1'b1);
    assign inc_r = mbx_addsub(src, BYTE_ONE, 1'b0);
    assign dec_r = mbx_addsub(src, BYTE_ONE, 1'b1);

    mbx_data_ram u_ram (
        .clk(clk),
        .raddr(ram_raddr),
        .rdata(ram_rdata),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata)
    );

    always_comb begin
        next_st = st;
        next_st.io_wr.we = 1'b0;
        next_st.soft_reset = 1'b0;
        next_st.wdt_clear = 1'b0;
        ram_raddr = ir.val[RAM_AW-1:0];
        ram_we = 1'b0;
        ram_waddr = ir.val[RAM_AW-1:0];
        ram_wdata = 8'h00;
        res = 8'h00;
        put = 1'b0;
        case (st.phase)
            ph_run: begin
                next_st.pc = pc_inc;
                if (take_irq) begin
                    // Entry behaves as a call that pushes the interrupted pc
                    ram_we = 1'b1;
                    ram_waddr = st.sp[RAM_AW-1:0];
                    ram_wdata = st.pc[7:0];
                    next_st.link = st.pc;
                    next_st.pc = IRQ_VECTOR;
                    next_st.gie = 1'b0;
                    next_st.op2 = op_call;
                    next_st.phase = ph_second;
                end else begin
                    case (ir.op)
                        op_and: begin
                            res = st.accumulator & opnd;
                            put = 1'b1;
                        end
                        op_or: begin
                            res = st.accumulator | opnd;
                            put = 1'b1;
                        end
                        op_xor: begin
                            res = st.accumulator ^ opnd;
                            put = 1'b1;
                        end
                        op_not: begin
                            res = ~src;
                            put = 1'b1;
                        end
                        op_neg: begin
                            res = 8'h00 - src;
                            put = 1'b1;
                        end
                        op_xor_io: begin
                            next_st.io_wr = '{we: 1'b1, addr: ir.val, data: io_rdata ^ st.accumulator};
                        end
                        op_bit_clear_io: begin
                            next_st.io_wr = '{we: 1'b1, addr: ir.val, data: io_rdata & ~bmask};
                        end
                        op_bit_set_io: begin
                            next_st.io_wr = '{we: 1'b1, addr: ir.val, data: io_rdata | bmask};
                        end
                        op_bit_clear_mem: begin
                            ram_we = bit_ok;
                            ram_wdata = ram_rdata & ~bmask;
                        end
                        op_bit_set_mem: begin
                            ram_we = bit_ok;
                            ram_wdata = ram_rdata | bmask;
                        end
                        op_swapc: begin
                            // Port logic routes the latch to the pin only when it is an output
                            next_st.io_wr.we = 1'b1;
                            next_st.io_wr.addr = ir.val;
                            next_st.io_wr.data = st.flags.carry_flag ? (io_rdata | bmask) : (io_rdata & ~bmask);
                            next_st.flags.carry_flag = io_rdata[ir.bitn];
                        end
                        op_ceqsn: begin
                            next_st.flags = cmp_r.flags;
                            if (st.accumulator == opnd) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_cneqsn: begin
                            next_st.flags = cmp_r.flags;
                            if (st.accumulator != opnd) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_skip_if_bit_low_io: begin
                            if (!io_rdata[ir.bitn]) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_skip_if_bit_high_io: begin
                            if (io_rdata[ir.bitn]) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_skip_if_bit_low_mem: begin
                            if (bit_ok && !ram_rdata[ir.bitn]) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_skip_if_bit_high_mem: begin
                            if (bit_ok && ram_rdata[ir.bitn]) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_izsn: begin
                            res = inc_r.res;
                            put = 1'b1;
                            next_st.flags = inc_r.flags;
                            if (inc_r.flags.zero_flag) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_dzsn: begin
                            res = dec_r.res;
                            put = 1'b1;
                            next_st.flags = dec_r.flags;
                            if (dec_r.flags.zero_flag) begin
                                next_st.phase = ph_skip;
                            end
                        end
                        op_call: begin
                            ram_we = 1'b1;
                            ram_waddr = st.sp[RAM_AW-1:0];
                            ram_wdata = pc_inc[7:0];
                            next_st.link = pc_inc;
                            next_st.pc = ir.target;
                            next_st.op2 = op_call;
                            next_st.phase = ph_second;
                        end
                        op_goto: begin
                            next_st.pc = ir.target;
                            next_st.op2 = op_goto;
                            next_st.phase = ph_second;
                        end
                        op_pcadd: begin
                            next_st.pc = st.pc + {3'b000, st.accumulator};
                            next_st.op2 = op_goto;
                            next_st.phase = ph_second;
                        end
                        op_ret, op_ret_imm, op_reti: begin
                            if (ir.op == op_ret_imm) begin
                                next_st.accumulator = ir.val;
                            end
                            ram_raddr = 7'(st.sp - SP_STEP);
                            next_st.ptr = ram_rdata;
                            next_st.op2 = (ir.op == op_reti) ? op_reti : op_ret;
                            next_st.phase = ph_second;
                        end
                        op_idxm_rd, op_idxm_wr: begin
                            next_st.ptr = ram_rdata;
                            next_st.op2 = ir.op;
                            next_st.phase = ph_second;
                        end
                        op_engint: begin
                            next_st.gie = 1'b1;
                        end
                        op_disgint: begin
                            next_st.gie = 1'b0;
                        end
                        op_stopsys: begin
                            next_st.full_halt = 1'b1;
                            next_st.phase = ph_halt;
                        end
                        op_stopexe: begin
                            next_st.full_halt = 1'b0;
                            next_st.phase = ph_halt;
                        end
                        op_reset: begin
                            next_st.soft_reset = 1'b1;
                        end
                        op_wdreset: begin
                            next_st.wdt_clear = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                    if (put) begin
                        next_st.flags.zero_flag = (res == 8'h00);
                        if (ir.to_mem) begin
                            ram_we = 1'b1;
                            ram_wdata = res;
                        end else begin
                            next_st.accumulator = res;
                        end
                    end
                end
            end
            ph_second: begin
                next_st.phase = ph_run;
                case (st.op2)
                    op_call: begin
                        ram_we = 1'b1;
                        ram_waddr = 7'(st.sp + SP_HIGH);
                        ram_wdata = {5'b00000, st.link[10:8]};
                        next_st.sp = st.sp + SP_STEP;
                    end
                    op_ret, op_reti: begin
                        ram_raddr = 7'(st.sp - SP_HIGH);
                        next_st.pc = {ram_rdata[2:0], st.ptr};
                        next_st.sp = st.sp - SP_STEP;
                        if (st.op2 == op_reti) begin
                            next_st.gie = 1'b1;
                        end
                    end
                    op_idxm_rd: begin
                        ram_raddr = st.ptr[RAM_AW-1:0];
                        next_st.accumulator = ram_rdata;
                    end
                    op_idxm_wr: begin
                        ram_we = 1'b1;
                        ram_waddr = st.ptr[RAM_AW-1:0];
                        ram_wdata = st.accumulator;
                    end
                    default: begin
                    end
                endcase
            end
            ph_skip: begin
                // Word at pc is fetched here but never decoded
                next_st.pc = pc_inc;
                next_st.phase = ph_run;
            end
            ph_halt: begin
                if (wake_req) begin
                    next_st.phase = ph_run;
                end
            end
            default: begin
                next_st.phase = ph_run;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prog_addr = st.pc;
    assign io_raddr = ir.val;
    // IO writes land one cycle late; a read of the same register right after sees the old value
    assign io_wr = st.io_wr;
    assign gie = st.gie;
    assign halt_cpu = (st.phase == ph_halt);
    assign halt_osc = (st.phase == ph_halt) && st.full_halt;
    assign soft_reset = st.soft_reset;
    assign wdt_clear = st.wdt_clear;
    assign status = '{accumulator: st.accumulator, flags: st.flags, sp: st.sp};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_and_flags;
        exec && ir.op == op_and |=> $stable(st.flags.carry_flag) && $stable(st.flags.half_carry_flag)
            && $stable(st.flags.signed_overflow_flag)
            && st.flags.zero_flag == (($past(st.accumulator) & $past(opnd)) == 8'h00);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and changed a flag wrongly");

    property p_xor_io;
        exec && ir.op == op_xor_io |=> io_wr.we && io_wr.data == ($past(io_rdata) ^ $past(st.accumulator))
            && io_wr.addr == $past(ir.val) && $stable(st.flags);
    endproperty
    a_xor_io: assert property (p_xor_io) else $error("xor into io wrong");

    property p_bit_set_io;
        exec && ir.op == op_bit_set_io |=> io_wr.we && io_wr.data == ($past(io_rdata) | $past(bmask));
    endproperty
    a_bit_set_io: assert property (p_bit_set_io) else $error("io bit set wrong");

    property p_ceq_skip;
        exec && ir.op == op_ceqsn && st.accumulator == opnd |=> st.phase == ph_skip ##1 st.phase == ph_run;
    endproperty
    a_ceq_skip: assert property (p_ceq_skip) else $error("equal compare did not skip once");

    property p_cne_noskip;
        exec && ir.op == op_cneqsn && st.accumulator == opnd |=> st.phase == ph_run;
    endproperty
    a_cne_noskip: assert property (p_cne_noskip) else $error("unequal compare skipped on equal");

    property p_call_sp;
        exec && ir.op == op_call |=> st.pc == $past(ir.target) ##1 st.sp == $past(st.sp, 2) + SP_STEP;
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call target or sp wrong");

    property p_ret_sp;
        exec && ir.op == op_ret |-> ##2 st.sp == $past(st.sp, 2) - SP_STEP;
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("return sp wrong");

    property p_reti_gie;
        exec && ir.op == op_reti |-> ##2 st.gie && $stable(st.flags);
    endproperty
    a_reti_gie: assert property (p_reti_gie) else $error("reti left interrupts off");

    property p_pcadd;
        exec && ir.op == op_pcadd |=> st.pc == $past(st.pc) + {3'b000, $past(st.accumulator)};
    endproperty
    a_pcadd: assert property (p_pcadd) else $error("computed jump target wrong");

    property p_disgint;
        exec && ir.op == op_disgint |=> !st.gie ##1 !take_irq;
    endproperty
    a_disgint: assert property (p_disgint) else $error("interrupt not blocked");

    property p_stopsys;
        exec && ir.op == op_stopsys |=> halt_osc && halt_cpu;
    endproperty
    a_stopsys: assert property (p_stopsys) else $error("full halt not entered");

    property p_soft_reset;
        exec && ir.op == op_reset |=> soft_reset ##1 !soft_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("software reset pulse wrong");

    property p_bit_ram_limit;
        exec && (ir.op == op_bit_set_mem || ir.op == op_bit_clear_mem) && ir.val > BIT_RAM_LAST |-> !ram_we;
    endproperty
    a_bit_ram_limit: assert property (p_bit_ram_limit) else $error("bit write above bit range");

endmodule : mbx_exec
`default_nettype wire

// ---- rtl/mbx_pkg.sv ----
// Shared types, constants and flag arithmetic of the logic, bit and branch execution core
package mbx_pkg;

    localparam int RAM_DEPTH = 128;
    localparam int RAM_AW = 7;
    localparam logic [7:0] BIT_RAM_LAST = 8'h3f;
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [10:0] PC_STEP = 11'h001;
    localparam logic [10:0] IRQ_VECTOR = 11'h010;
    localparam logic [7:0] SP_RESET = 8'h40;
    localparam logic [7:0] SP_STEP = 8'h02;
    localparam logic [7:0] SP_HIGH = 8'h01;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    typedef enum logic [5:0] {
        op_nop, op_and, op_or, op_xor, op_xor_io, op_not, op_neg,
        op_bit_clear_io, op_bit_set_io, op_bit_clear_mem, op_bit_set_mem, op_swapc,
        op_ceqsn, op_cneqsn, op_skip_if_bit_low_io, op_skip_if_bit_high_io,
        op_skip_if_bit_low_mem, op_skip_if_bit_high_mem, op_izsn, op_dzsn,
        op_call, op_goto, op_ret, op_ret_imm, op_reti, op_pcadd,
        op_engint, op_disgint, op_stopsys, op_stopexe, op_reset, op_wdreset,
        op_idxm_rd, op_idxm_wr
    } mbx_op_t;

    typedef enum logic [1:0] {ph_run, ph_second, ph_skip, ph_halt} mbx_phase_t;

    typedef struct packed {
        mbx_op_t op;
        logic to_mem;
        logic use_imm;
        logic [7:0] val;
        logic [2:0] bitn;
        logic [10:0] target;
    } mbx_instr_t;

    typedef struct packed {
        logic zero_flag;
        logic carry_flag;
        logic half_carry_flag;
        logic signed_overflow_flag;
    } mbx_flags_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } mbx_io_wr_t;

    typedef struct packed {
        logic [7:0] accumulator;
        mbx_flags_t flags;
        logic [7:0] sp;
    } mbx_status_t;

    typedef struct packed {
        logic [7:0] res;
        mbx_flags_t flags;
    } mbx_alu_t;

    typedef struct packed {
        mbx_phase_t phase;
        mbx_op_t op2;
        logic [10:0] pc;
        logic [10:0] link;
        logic [7:0] sp;
        logic [7:0] accumulator;
        mbx_flags_t flags;
        logic gie;
        logic [7:0] ptr;
        logic full_halt;
        mbx_io_wr_t io_wr;
        logic soft_reset;
        logic wdt_clear;
    } mbx_state_t;

    localparam mbx_state_t STATE_RESET = '{phase: ph_run, op2: op_nop, pc: PC_RESET, link: 11'h000,
        sp: SP_RESET, accumulator: ACC_RESET, flags: 4'h0, gie: 1'b0, ptr: 8'h00, full_halt: 1'b0,
        io_wr: 17'h00000, soft_reset: 1'b0, wdt_clear: 1'b0};

    // Carry and half carry are borrows when subtracting
    function automatic mbx_alu_t mbx_addsub(input logic [7:0] a, input logic [7:0] b, input logic sub);
        logic [8:0] full;
        logic [4:0] low;
        mbx_alu_t r;
        full = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        low = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
        r.res = full[7:0];
        r.flags.zero_flag = (full[7:0] == 8'h00);
        r.flags.carry_flag = full[8];
        r.flags.half_carry_flag = low[4];
        r.flags.signed_overflow_flag = sub ? ((a[7] ^ b[7]) & (a[7] ^ full[7]))
                                           : (~(a[7] ^ b[7]) & (a[7] ^ full[7]));
        return r;
    endfunction : mbx_addsub

endpackage : mbx_pkg
